// ==== core/ptp_pkg.sv ====
// package for the period timer pwm channel: register map, fields, reset values
package ptp_pkg;

    // register byte addresses on the avalon word bus
    localparam logic [3:0] OFS_PERIOD_COUNTER = 4'h0;
    localparam logic [3:0] OFS_PERIOD_LIMIT   = 4'h1;
    localparam logic [3:0] OFS_TIMER_CONTROL  = 4'h2;
    localparam logic [3:0] OFS_DUTY_BUFFER    = 4'h3;
    localparam logic [3:0] OFS_CHANNEL_CTRL   = 4'h4;
    localparam logic [3:0] OFS_DUTY_ACTIVE    = 4'h5;
    localparam logic [3:0] OFS_PERIPH_FLAG    = 4'h6;

    // timer control fields
    localparam int TC_PRESCALE_LSB  = 0;
    localparam int TC_RUN_BIT       = 2;
    localparam int TC_POSTSCALE_LSB = 3;
    localparam int TC_UNUSED_BIT    = 7;
    // channel control fields
    localparam int CC_MODE_LSB      = 0;
    localparam int CC_DUTY_LSB      = 4;
    // peripheral flag register position of the period match flag
    localparam int PF_MATCH_BIT     = 3;

    // channel mode code for pulse-width operation (bits 3:0)
    localparam logic [3:0] CC_MODE_PWM = 4'hC;

    // reset values
    localparam logic [7:0] RST_TIMER_CONTROL = 8'h00;
    localparam logic [7:0] RST_PERIOD_LIMIT  = 8'hFF;
    localparam logic [7:0] RST_ZERO8         = 8'h00;
    localparam logic [9:0] RST_ZERO10        = 10'h000;

    // prescaler terminal counts (divide minus one)
    localparam logic [3:0] PRE_TC_1  = 4'h0;
    localparam logic [3:0] PRE_TC_4  = 4'h3;
    localparam logic [3:0] PRE_TC_16 = 4'hF;

    // instruction clock is the bus clock divided by four
    localparam logic [1:0] INSTR_DIV_TC = 2'h3;

    // avalon request bundle
    typedef struct packed {
        logic [3:0] address;
        logic       read;
        logic       write;
        logic [7:0] writedata;
    } ptp_req_type;

endpackage

// ==== core/ptp_pwm_timer.sv ====
// period timer with prescaler/postscaler driving one 10-bit pwm channel
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////////
// What this block does
// - 8-bit counter and period register, read/write
// - counter advances only while run bit set
// - prescale select 00 /1, 01 /4, 1x /16
// - postscaler divides matches by field plus one
// - postscaler event sets sticky period match flag
// - counter or control write clears pre/postscalers
// - control write leaves counter value alone
// - counter clears to zero on reset
// - control bit 7 reads zero, ignores writes
// - timer serves as pwm time base
// - pwm output has 10-bit high time resolution
// - period is (limit+1) times 4 times prescale
// - after match: clear counter, pin high unless duty zero, reload duty
// - postscaler never changes the pwm period
// - duty is buffer byte plus control bits 5:4
// - duty copied to active only at period end
// - active duty read-only in pwm mode
// - clearing channel control forces output latch low
module ptp_pwm_timer
    import ptp_pkg::*;
(
    // clock and reset
    input  wire logic       sys_clk,
    input  wire logic       arst_n,
    // avalon-mm slave
    input  wire logic [3:0] avs_address,
    input  wire logic       avs_read,
    input  wire logic       avs_write,
    input  wire logic [7:0] avs_writedata,
    output logic      [7:0] avs_readdata,
    output logic            avs_waitrequest,
    // pwm pin
    output logic            pwm_output_pin
);

    ////////////////////////////////////////////////////////////////////////////
    // reset synchroniser
    logic       rst_meta_n;     // first stage only
    logic       rst_n;          // released copy
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_meta_n <= 1'b0;
            rst_n      <= 1'b0;
        end else begin
            rst_meta_n <= 1'b1;
            rst_n      <= rst_meta_n;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers and state
    ptp_req_type req;
    logic [7:0] period_counter_r;       // timer count
    logic [7:0] period_limit_r;         // period limit
    logic [6:0] timer_control_r;        // bit 7 not stored
    logic [7:0] duty_buffer_r;          // duty msbs
    logic [7:0] channel_control_r;      // mode and duty lsbs
    logic [9:0] duty_active_r;          // latched duty
    logic       period_match_flag_r;    // sticky flag
    logic [1:0] instr_div_r;            // osc/4 divider
    logic [3:0] prescale_cnt_r;         // prescaler count
    logic [3:0] postscale_cnt_r;        // postscaler count
    logic       ack_r;                  // answer phase

    assign req = '{avs_address, avs_read, avs_write, avs_writedata};

    // one-cycle wait then answer: simple registered read path
    wire bus_go   = (req.read | req.write) & ~ack_r;
    wire wr_fire  = req.write & ack_r;
    wire wr_cnt   = wr_fire & (req.address == OFS_PERIOD_COUNTER);
    wire wr_lim   = wr_fire & (req.address == OFS_PERIOD_LIMIT);
    wire wr_tc    = wr_fire & (req.address == OFS_TIMER_CONTROL);
    wire wr_dbuf  = wr_fire & (req.address == OFS_DUTY_BUFFER);
    wire wr_cc    = wr_fire & (req.address == OFS_CHANNEL_CTRL);
    wire wr_pf    = wr_fire & (req.address == OFS_PERIPH_FLAG);

    ////////////////////////////////////////////////////////////////////////////
    // time base decode
    wire       run      = timer_control_r[TC_RUN_BIT];
    wire [1:0] pre_sel  = timer_control_r[TC_PRESCALE_LSB +: 2];
    wire [3:0] post_sel = timer_control_r[TC_POSTSCALE_LSB +: 4];
    wire       pwm_mode = (channel_control_r[CC_MODE_LSB +: 4] == CC_MODE_PWM);
    // quarter-phase tick: the clock is the oscillator here
    wire       instr_tick = (instr_div_r == INSTR_DIV_TC);
    logic [3:0] pre_tc;
    always_comb begin
        // 1x picks divide by sixteen                                     
        unique case (pre_sel)
            2'h0:    pre_tc = PRE_TC_1;
            2'h1:    pre_tc = PRE_TC_4;
            default: pre_tc = PRE_TC_16;
        endcase
    end
    wire pre_tick   = run & instr_tick & (prescale_cnt_r == pre_tc);
    wire match      = (period_counter_r == period_limit_r);
    wire period_end = pre_tick & match;
    wire post_event = period_end & (postscale_cnt_r == post_sel);
    // extended count: counter plus two top bits of sub-count
    logic [1:0] sub_bits;
    always_comb begin
        unique case (pre_sel)
            2'h0:    sub_bits = instr_div_r;
            2'h1:    sub_bits = prescale_cnt_r[1:0];
            default: sub_bits = prescale_cnt_r[3:2];
        endcase
    end
    wire [9:0] ext_count = {period_counter_r, sub_bits};
    // step of the extended count: the sub bits move at the prescaled
    // quarter rate, so one timer count always spans exactly four steps
    logic       ext_step;
    always_comb begin
        // rate follows the prescale choice
        unique case (pre_sel)
            2'h0:    ext_step = run;
            2'h1:    ext_step = run & instr_tick;
            default: ext_step = run & instr_tick & (prescale_cnt_r[1:0] == 2'h3);
        endcase
    end
    // look ahead one step: the pin is already low on the count that equals
    // the duty, so the high time is duty counts, not duty plus one; the
    // registered pin would otherwise lag the compare by one cycle
    wire [9:0] ext_next  = ext_count + 10'h001;
    wire       duty_fall = ext_step & (ext_next == duty_active_r);

    ////////////////////////////////////////////////////////////////////////////
    // oscillator divide-by-four, free running
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            instr_div_r <= 2'h0;
        end else begin
            instr_div_r <= instr_div_r + 2'h1;
        end
    end

    // prescaler counter, cleared by counter or control writes
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            prescale_cnt_r <= 4'h0;
        end else if (wr_cnt | wr_tc) begin
            prescale_cnt_r <= 4'h0;
        end else if (run & instr_tick) begin
            prescale_cnt_r <= pre_tick ? 4'h0 : prescale_cnt_r + 4'h1;
        end
    end

    // postscaler counts period matches only; pwm period ignores it
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            postscale_cnt_r <= 4'h0;
        end else if (wr_cnt | wr_tc) begin
            postscale_cnt_r <= 4'h0;
        end else if (period_end) begin
            postscale_cnt_r <= post_event ? 4'h0 : postscale_cnt_r + 4'h1;
        end
    end

    // timer count: wraps after limit, so period is limit+1 ticks
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            period_counter_r <= RST_ZERO8;
        end else if (wr_cnt) begin
            period_counter_r <= req.writedata;
        end else if (period_end) begin
            period_counter_r <= RST_ZERO8;
        end else if (pre_tick) begin
            period_counter_r <= period_counter_r + 8'h01;
        end
    end

    // period limit
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            period_limit_r <= RST_PERIOD_LIMIT;
        end else if (wr_lim) begin
            period_limit_r <= req.writedata;
        end
    end

    // timer control: bit 7 dropped, counter untouched by this write
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            timer_control_r <= RST_TIMER_CONTROL[6:0];
        end else if (wr_tc) begin
            timer_control_r <= req.writedata[6:0];
        end
    end

    // duty buffer and channel control, writable any time
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            duty_buffer_r     <= RST_ZERO8;
            channel_control_r <= RST_ZERO8;
        end else begin
            if (wr_dbuf) begin
                duty_buffer_r <= req.writedata;
            end
            if (wr_cc) begin
                channel_control_r <= req.writedata;
            end
        end
    end

    // active duty: loaded only at period end, never by software
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            duty_active_r <= RST_ZERO10;
        end else if (period_end) begin
            duty_active_r <= {duty_buffer_r,
                              channel_control_r[CC_DUTY_LSB +: 2]};
        end
    end

    // sticky flag: hardware set wins over software clear
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            period_match_flag_r <= 1'b0;
        end else if (post_event) begin
            period_match_flag_r <= 1'b1;
        end else if (wr_pf & ~req.writedata[PF_MATCH_BIT]) begin
            period_match_flag_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pwm output latch
    wire [9:0] next_duty = {duty_buffer_r, channel_control_r[CC_DUTY_LSB +: 2]};
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pwm_output_pin <= 1'b0;
        end else if (channel_control_r == 8'h00 || !pwm_mode) begin
            pwm_output_pin <= 1'b0;
        end else if (period_end) begin
            pwm_output_pin <= (next_duty != RST_ZERO10);
        end else if (duty_fall) begin
            // stays low from here to the next period start
            pwm_output_pin <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // avalon answer: waitrequest low one cycle after request
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_r           <= 1'b0;
            avs_waitrequest <= 1'b1;
            avs_readdata    <= RST_ZERO8;
        end else begin
            ack_r           <= bus_go;
            avs_waitrequest <= ~bus_go;
            if (bus_go && req.read) begin
                unique case (req.address)
                    OFS_PERIOD_COUNTER: avs_readdata <= period_counter_r;
                    OFS_PERIOD_LIMIT:   avs_readdata <= period_limit_r;
                    OFS_TIMER_CONTROL:  avs_readdata <= {1'b0, timer_control_r};
                    OFS_DUTY_BUFFER:    avs_readdata <= duty_buffer_r;
                    OFS_CHANNEL_CTRL:   avs_readdata <= channel_control_r;
                    OFS_DUTY_ACTIVE:    avs_readdata <= duty_active_r[9:2];
                    OFS_PERIPH_FLAG:    avs_readdata <= {4'h0, period_match_flag_r, 3'h0};
                    default:            avs_readdata <= RST_ZERO8;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    sequence s_end;
        period_end;
    endsequence
    property p_run_gate;
        @(posedge sys_clk) disable iff (!rst_n)
        !run && !wr_cnt |=> $stable(period_counter_r);
    endproperty
    a_run_gate: assert property (p_run_gate) else $error("counter moved while stopped");
    property p_wrap;
        @(posedge sys_clk) disable iff (!rst_n)
        s_end and !wr_cnt |=> period_counter_r == 8'h00;
    endproperty
    a_wrap: assert property (p_wrap) else $error("counter not cleared at period end");
    property p_flag;
        @(posedge sys_clk) disable iff (!rst_n)
        post_event |=> period_match_flag_r;
    endproperty
    a_flag: assert property (p_flag) else $error("flag not set");
    property p_tc_keep;
        @(posedge sys_clk) disable iff (!rst_n)
        wr_tc && !pre_tick |=> period_counter_r == $past(period_counter_r)
                                && prescale_cnt_r == 4'h0 && postscale_cnt_r == 4'h0;
    endproperty
    a_tc_keep: assert property (p_tc_keep) else $error("control write side effect wrong");
    property p_bit7;
        @(posedge sys_clk) disable iff (!rst_n)
        bus_go && req.read && req.address == OFS_TIMER_CONTROL |=> !avs_readdata[7];
    endproperty
    a_bit7: assert property (p_bit7) else $error("bit 7 read nonzero");
    property p_latch;
        @(posedge sys_clk) disable iff (!rst_n)
        !period_end |=> $stable(duty_active_r);
    endproperty
    a_latch: assert property (p_latch) else $error("duty changed mid period");
    property p_zero_duty;
        @(posedge sys_clk) disable iff (!rst_n)
        s_end and next_duty == 10'h000 |=> !pwm_output_pin;
    endproperty
    a_zero_duty: assert property (p_zero_duty) else $error("pin set at zero duty");
    property p_cc_clear;
        @(posedge sys_clk) disable iff (!rst_n)
        channel_control_r == 8'h00 |=> !pwm_output_pin;
    endproperty
    a_cc_clear: assert property (p_cc_clear) else $error("pin high with control clear");
    // divide by sixteen: every quarter tick steps the 4-bit count, F wraps to 0
    property p_pre16;
        @(posedge sys_clk) disable iff (!rst_n)
        pre_sel[1] && run && instr_tick && !wr_cnt && !wr_tc
            |=> prescale_cnt_r == $past(prescale_cnt_r) + 4'h1;
    endproperty
    a_pre16: assert property (p_pre16) else $error("prescale 16 wrong");
    // bus answer: one wait cycle, then a single low cycle of waitrequest
    sequence s_take;
        bus_go;
    endsequence
    sequence s_answer;
        !avs_waitrequest ##1 avs_waitrequest;
    endsequence
    property p_answer;
        @(posedge sys_clk) disable iff (!rst_n)
        s_take |=> s_answer;
    endproperty
    a_answer: assert property (p_answer) else $error("bus answer timing wrong");
    // pin drops on the step that reaches the duty count
    property p_fall;
        @(posedge sys_clk) disable iff (!rst_n)
        duty_fall && !period_end |=> !pwm_output_pin;
    endproperty
    a_fall: assert property (p_fall) else $error("pin high past duty count");

endmodule

// ==== tb/ptp_load_model.sv ====
// load model on the pwm pin: measures high time and period
`timescale 1ns/100ps

module ptp_load_model (
    // clock
    input  wire logic sys_clk,
    // pwm pin from the device
    input  wire logic pin,
    // measurements, in clock cycles
    output int        high_len,
    output int        period_len,
    output int        n_rise
);
    logic pin_r  = 1'b0; // level seen at the previous edge
    int   hcnt   = 0;    // high cycles in this period
    int   pcnt   = 0;    // cycles since the last rise
    int   high_q = 0;    // last complete high time
    int   per_q  = 0;    // last complete period
    int   rise_q = 0;    // rises seen

    assign high_len   = high_q;
    assign period_len = per_q;
    assign n_rise     = rise_q;

    // resistive load: only samples, never drives back, so no release hazard
    always @(posedge sys_clk) begin
        pin_r <= pin;
        pcnt  <= pcnt + 1;
        if (pin) begin
            hcnt <= hcnt + 1;
        end
        // rise: one period is complete
        if (pin && !pin_r) begin
            per_q  <= pcnt;
            pcnt   <= 1;
            hcnt   <= 1;
            rise_q <= rise_q + 1;
        end
        // fall: the high time is complete
        if (!pin && pin_r) begin
            high_q <= hcnt;
        end
    end
endmodule

// ==== tb/testbench.sv ====
// self-checking bench for the period timer pwm channel
`timescale 1ns/100ps

module testbench;
    import ptp_pkg::*;

    // design drive and observation
    logic       sys_clk         = 1'b0;
    logic       arst_n          = 1'b0;
    logic [3:0] avs_address     = 4'h0;
    logic       avs_read        = 1'b0;
    logic       avs_write       = 1'b0;
    logic [7:0] avs_writedata   = 8'h00;
    logic [7:0] avs_readdata;
    logic       avs_waitrequest;
    logic       pwm_output_pin;
    // load measurements and bookkeeping
    int         high_len;
    int         period_len;
    int         n_rise;
    int         n_mismatch      = 0;
    int         samples_checked = 0;
    int         pre;             // prescale factor under test
    int         rises_before;    // rise count at a reference point
    logic [7:0] q;               // last read data

    // 25 MHz clock
    always #20 sys_clk = ~sys_clk;

    ptp_pwm_timer dut (
        .sys_clk         (sys_clk),
        .arst_n          (arst_n),
        .avs_address     (avs_address),
        .avs_read        (avs_read),
        .avs_write       (avs_write),
        .avs_writedata   (avs_writedata),
        .avs_readdata    (avs_readdata),
        .avs_waitrequest (avs_waitrequest),
        .pwm_output_pin  (pwm_output_pin)
    );

    ptp_load_model load (
        .sys_clk    (sys_clk),
        .pin        (pwm_output_pin),
        .high_len   (high_len),
        .period_len (period_len),
        .n_rise     (n_rise)
    );

    ////////////////////////////////////////////////////////////////
    // compare and count; four-state so an unknown never matches
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one bus cycle: request held until waitrequest is sampled low
    task automatic bus(input logic rd, input logic [3:0] a, input logic [7:0] d);
        int i = 0;
        @(posedge sys_clk);
        avs_address   <= a;
        avs_writedata <= d;
        avs_read      <= rd;
        avs_write     <= !rd;
        do begin
            @(posedge sys_clk);
            i++;
        end while (avs_waitrequest !== 1'b0 && i < 64);
        q = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        // a slave that never answers counts as a mismatch
        if (i >= 64) begin
            n_mismatch++;
            $display("unexpected at %0t: no answer %h %h", $time, a, d);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        bus(1'b0, a, d);
    endtask

    task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
        bus(1'b1, a, 8'h00);
        check(q, e);
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    // the one place the run ends
    task automatic finish_test;
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // watchdog: tests need about 3000 cycles
    initial begin
        #(40 * 20000);
        n_mismatch++;
        $display("unexpected at %0t: watchdog %h %h", $time, 1'b0, 1'b1);
        finish_test();
    end

    ////////////////////////////////////////////////////////////////
    initial begin
        cyc(16);
        arst_n <= 1'b1;
        cyc(3);
        // reset values, and an unmapped place
        rd_chk(OFS_PERIOD_COUNTER, RST_ZERO8);
        rd_chk(OFS_PERIOD_LIMIT, RST_PERIOD_LIMIT);
        rd_chk(OFS_TIMER_CONTROL, RST_TIMER_CONTROL);
        rd_chk(OFS_DUTY_ACTIVE, 8'h00);
        rd_chk(OFS_PERIPH_FLAG, 8'h00);
        wr(4'h7, 8'hA5);
        rd_chk(4'h7, 8'h00);
        $display("test reset values done");
        // register access with the timer stopped
        wr(OFS_PERIOD_LIMIT, 8'h5A);
        rd_chk(OFS_PERIOD_LIMIT, 8'h5A);
        wr(OFS_PERIOD_COUNTER, 8'h33);
        wr(OFS_TIMER_CONTROL, 8'h83);
        rd_chk(OFS_TIMER_CONTROL, 8'h03);
        rd_chk(OFS_PERIOD_COUNTER, 8'h33);
        cyc(40);
        rd_chk(OFS_PERIOD_COUNTER, 8'h33);
        $display("test register access done");
        // period and high time for each prescale code, postscale 1:6
        wr(OFS_PERIOD_LIMIT, 8'h03);
        wr(OFS_PERIOD_COUNTER, 8'h00);
        wr(OFS_DUTY_BUFFER, 8'h02);
        wr(OFS_CHANNEL_CTRL, 8'h1C);
        for (int ps = 0; ps < 4; ps++) begin
            pre = (ps == 0) ? 1 : (ps == 1) ? 4 : 16;
            wr(OFS_TIMER_CONTROL, 8'h2C | 8'(ps));
            wr(OFS_PERIOD_COUNTER, 8'h00);
            cyc(64 * pre);
            check(period_len, 16 * pre);
            check(high_len, 9 * pre);
        end
        $display("test pwm timing done");
        // duty moves to the active register only at period end
        wr(OFS_TIMER_CONTROL, 8'h00);
        wr(OFS_DUTY_BUFFER, 8'h03);
        rd_chk(OFS_DUTY_ACTIVE, 8'h02);
        wr(OFS_DUTY_ACTIVE, 8'hAA);
        rd_chk(OFS_DUTY_ACTIVE, 8'h02);
        wr(OFS_TIMER_CONTROL, 8'h04);
        cyc(64);
        rd_chk(OFS_DUTY_ACTIVE, 8'h03);
        check(high_len, 13);
        $display("test duty reload done");
        // postscale 1:16: flag after sixteen matches, period unchanged
        wr(OFS_TIMER_CONTROL, 8'h7C);
        wr(OFS_PERIPH_FLAG, 8'h00);
        cyc(200);
        bus(1'b1, OFS_PERIPH_FLAG, 8'h00);
        check(q[PF_MATCH_BIT], 1'b0);
        cyc(100);
        bus(1'b1, OFS_PERIPH_FLAG, 8'h00);
        check(q[PF_MATCH_BIT], 1'b1);
        check(period_len, 16);
        // postscale 1:1: every match sets the flag
        wr(OFS_TIMER_CONTROL, 8'h04);
        wr(OFS_PERIPH_FLAG, 8'h00);
        cyc(20);
        bus(1'b1, OFS_PERIPH_FLAG, 8'h00);
        check(q[PF_MATCH_BIT], 1'b1);
        $display("test postscaler done");
        // zero duty keeps the pin low
        wr(OFS_DUTY_BUFFER, 8'h00);
        wr(OFS_CHANNEL_CTRL, 8'h0C);
        cyc(40);
        rises_before = n_rise;
        cyc(64);
        check(n_rise, rises_before);
        check(pwm_output_pin, 1'b0);
        // clearing channel control forces the pin low
        wr(OFS_DUTY_BUFFER, 8'h02);
        wr(OFS_CHANNEL_CTRL, 8'h1C);
        cyc(40);
        wr(OFS_CHANNEL_CTRL, 8'h00);
        rises_before = n_rise;
        cyc(64);
        check(n_rise, rises_before);
        check(pwm_output_pin, 1'b0);
        $display("test output off done");
        finish_test();
    end
endmodule
